// ===== hw/dct_pkg.sv
/*
 Constants, control layout and edge modes for the dual counter/timer block.
 Assumes an 8-bit expanded register bank with a 4-bit register index.
*/
package dct_pkg;

   localparam logic [3:0] DCT_OFS_BYTE_CTRL   = 4'h0;
   localparam logic [3:0] DCT_OFS_WORD_CTRL   = 4'h2;
   localparam logic [3:0] DCT_OFS_BYTE_INIT   = 4'h4;
   localparam logic [3:0] DCT_OFS_WORD_HOLD_L = 4'h6;
   localparam logic [3:0] DCT_OFS_WORD_HOLD_H = 4'h7;
   localparam logic [3:0] DCT_OFS_WORD_CAP_L  = 4'h8;
   localparam logic [3:0] DCT_OFS_WORD_CAP_H  = 4'h9;
   localparam logic [3:0] DCT_OFS_BYTE_CAP_L  = 4'hA;
   localparam logic [3:0] DCT_OFS_BYTE_CAP_H  = 4'hB;

   localparam int DCT_BIT_RUN     = 7;
   localparam int DCT_BIT_SINGLE  = 6;
   localparam int DCT_BIT_TIMEOUT = 5;

   localparam logic [7:0]  DCT_CTRL_RST   = 8'h00;
   localparam logic [7:0]  DCT_DATA_RST   = 8'h00;
   localparam logic [7:0]  DCT_BYTE_FULL  = 8'hFF;
   localparam logic [15:0] DCT_WORD_FULL  = 16'hFFFF;
   localparam logic [2:0]  DCT_PRE_RST    = 3'h0;

   typedef struct packed {
      logic       run;
      logic       single;
      logic       timeout;
      logic [1:0] prescale;
      logic       cap_mask;
      logic       tmo_mask;
      logic       pin_route;
   } dct_ctrl_s;

   typedef enum logic [1:0] {
      DCT_EDGE_FALL = 2'b00,
      DCT_EDGE_RISE = 2'b01,
      DCT_EDGE_BOTH = 2'b10,
      DCT_EDGE_NONE = 2'b11
   } dct_edge_e;

endpackage

// ===== hw/dct_prescale.sv
/*
 Free-running divider giving a count tick at clk, clk/2, clk/4 or clk/8.
 Assumes the divider is never reset by enabling a timer.
*/
`timescale 1ns/1ps
`default_nettype none
module dct_prescale
   import dct_pkg::*;
(
   input  wire logic       clk,      // System clock
   input  wire logic       resetn,   // Async reset, active low
   input  wire logic [1:0] sel,      // Division select
   output logic            tick      // One-cycle count pulse
);
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic [2:0] mask;

   always_comb
   begin
      next_cnt = cnt + 3'h1;
      mask     = 3'((4'h1 << sel) - 4'h1);
      tick     = ((cnt & mask) == mask);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         cnt <= DCT_PRE_RST;
      else
         cnt <= next_cnt;
   end
endmodule
`default_nettype wire

// ===== hw/dct_sync.sv
/*
 Two-flop synchroniser for one asynchronous level.
 Assumes the input is a pin outside the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dct_sync
   import dct_pkg::*;
(
   input  wire logic clk,      // System clock
   input  wire logic resetn,   // Async reset, active low
   input  wire logic d,        // Asynchronous level
   output logic      q         // Synchronised level
);
   logic meta;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta <= 1'b0;
         q    <= 1'b0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// ===== hw/dct_timer.sv
/*
 Byte and word down-counters with capture registers, timeout flags,
 single-pass/modulo-N control, demodulation capture and ping-pong chaining.
 Assumes a synchronous 8-bit register port in the clk domain; the
 demodulator input is an asynchronous pin.
*/
`timescale 1ns/1ps
`default_nettype none
module dct_timer
   import dct_pkg::*;
(
   input  wire logic       clk,             // System clock
   input  wire logic       resetn,          // Async reset, active low
   input  wire logic [3:0] reg_addr,        // Register index
   input  wire logic       reg_wr,          // Write strobe
   input  wire logic       reg_rd,          // Read strobe
   input  wire logic [7:0] reg_wdata,       // Write data
   output logic      [7:0] reg_rdata,       // Read data, one cycle later
   input  wire logic       demod_mode,      // 1 demodulation, 0 transmit
   input  wire logic       ping_pong,       // Ping-pong chaining select
   input  wire logic [1:0] edge_sel,        // Demodulator edge select
   input  wire logic       demod_in,        // Demodulator pin
   input  wire logic       rise_clr,        // Clears rising-edge flag
   input  wire logic       fall_clr,        // Clears falling-edge flag
   output logic            rise_flag,       // Rising edge detected
   output logic            fall_flag,       // Falling edge detected
   output logic            byte_tmo_irq,    // Byte timeout interrupt pulse
   output logic            word_tmo_irq,    // Word timeout interrupt pulse
   output logic            byte_cap_irq,    // Byte capture interrupt pulse
   output logic            word_cap_irq,    // Word capture interrupt pulse
   output logic            byte_timer_out,  // Byte timer toggle output
   output logic            word_timer_out,  // Word timer toggle output
   output logic            byte_timer_pin_route, // Byte output to pin
   output logic            word_timer_pin_route  // Word output to pin
);
   dct_ctrl_s   bctl, next_bctl, wctl, next_wctl;
   logic [7:0]  binit, next_binit, whold_l, next_whold_l;
   logic [7:0]  whold_h, next_whold_h;
   logic [7:0]  bcap_hi, next_bcap_hi, bcap_lo, next_bcap_lo;
   logic [7:0]  wcap_hi, next_wcap_hi, wcap_lo, next_wcap_lo;
   logic [7:0]  bcnt, next_bcnt;
   logic [15:0] wcnt, next_wcnt;
   logic        rise, next_rise, fall, next_fall, din_d, next_din_d;
   logic        bout, next_bout, wout, next_wout;
   logic        b_tmo_p, w_tmo_p, b_cap_p, w_cap_p;
   logic [7:0]  next_rdata;
   logic        din_s, btick, wtick, wr_b, wr_w;
   logic        pos_e, neg_e, b_edge, w_edge, b_term, w_term;
   logic        b_start, w_start;
   dct_edge_e   esel;

   dct_sync u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      (demod_in),
      .q      (din_s)
   );

   dct_prescale u_bpre (
      .clk    (clk),
      .resetn (resetn),
      .sel    (bctl.prescale),
      .tick   (btick)
   );

   dct_prescale u_wpre (
      .clk    (clk),
      .resetn (resetn),
      .sel    (wctl.prescale),
      .tick   (wtick)
   );

   always_comb
   begin
      esel  = dct_edge_e'(edge_sel);
      wr_b  = reg_wr && (reg_addr == DCT_OFS_BYTE_CTRL);
      wr_w  = reg_wr && (reg_addr == DCT_OFS_WORD_CTRL);
      pos_e = din_s && !din_d && demod_mode &&
              (esel == DCT_EDGE_RISE || esel == DCT_EDGE_BOTH);
      neg_e = !din_s && din_d && demod_mode &&
              (esel == DCT_EDGE_FALL || esel == DCT_EDGE_BOTH);
      b_edge = bctl.run && (pos_e || neg_e);
      w_edge = wctl.run && !wctl.single && (pos_e || neg_e);
      b_term = bctl.run && btick && (bcnt == 8'h00);
      w_term = wctl.run && wtick && (wcnt == 16'h0000);
      next_bctl    = bctl;
      next_wctl    = wctl;
      next_binit   = binit;
      next_whold_l = whold_l;
      next_whold_h = whold_h;
      next_bcap_hi = bcap_hi;
      next_bcap_lo = bcap_lo;
      next_wcap_hi = wcap_hi;
      next_wcap_lo = wcap_lo;
      next_bcnt    = bcnt;
      next_wcnt    = wcnt;
      next_din_d   = din_s;
      next_bout    = bout;
      next_wout    = wout;
      next_rise    = rise && !rise_clr;
      next_fall    = fall && !fall_clr;
      b_tmo_p      = 1'b0;
      w_tmo_p      = 1'b0;
      b_cap_p      = 1'b0;
      w_cap_p      = 1'b0;
      // Capture registers are not writable
      if (reg_wr)
      begin
         unique case (reg_addr)
            DCT_OFS_BYTE_INIT:   next_binit   = reg_wdata;
            DCT_OFS_WORD_HOLD_L: next_whold_l = reg_wdata;
            DCT_OFS_WORD_HOLD_H: next_whold_h = reg_wdata;
            default:             ;
         endcase
      end
      if (wr_b)
      begin
         next_bctl = dct_ctrl_s'(reg_wdata);
         next_bctl.timeout = bctl.timeout && !reg_wdata[DCT_BIT_TIMEOUT];
      end
      if (wr_w)
      begin
         next_wctl = dct_ctrl_s'(reg_wdata);
         next_wctl.timeout = wctl.timeout && !reg_wdata[DCT_BIT_TIMEOUT];
      end
      // Byte counting
      if (b_edge)
      begin
         if (pos_e)
            next_bcap_lo = bcnt;
         else
            next_bcap_hi = bcnt;
         next_bcnt = DCT_BYTE_FULL;
         b_cap_p   = bctl.cap_mask;
      end
      else if (b_term)
      begin
         next_bctl.timeout = 1'b1;
         b_tmo_p = bctl.tmo_mask;
         if (demod_mode)
            next_bcnt = DCT_BYTE_FULL;
         else
         begin
            next_bout = !bout;
            next_bcnt = binit;
            if (bctl.single && !wr_b)
               next_bctl.run = 1'b0;
         end
      end
      else if (bctl.run && btick)
         next_bcnt = bcnt - 8'h01;
      // Word counting
      if (w_edge)
      begin
         next_wcap_hi = wcnt[15:8];
         next_wcap_lo = wcnt[7:0];
         next_wcnt    = DCT_WORD_FULL;
         w_cap_p      = wctl.cap_mask;
      end
      else if (w_term)
      begin
         next_wctl.timeout = 1'b1;
         w_tmo_p = wctl.tmo_mask;
         if (demod_mode)
            next_wcnt = DCT_WORD_FULL;
         else
         begin
            next_wout = !wout;
            next_wcnt = {whold_h, whold_l};
            if (wctl.single && !wr_w)
               next_wctl.run = 1'b0;
         end
      end
      else if (wctl.run && wtick)
         next_wcnt = wcnt - 16'h0001;
      if (pos_e && (b_edge || w_edge))
         next_rise = 1'b1;
      if (neg_e && (b_edge || w_edge))
         next_fall = 1'b1;
      // Ping-pong: a single-pass finish starts the partner
      if (ping_pong && !demod_mode && b_term && bctl.single)
         next_wctl.run = 1'b1;
      if (ping_pong && !demod_mode && w_term && wctl.single)
         next_bctl.run = 1'b1;
      b_start = next_bctl.run && !bctl.run;
      w_start = next_wctl.run && !wctl.run;
      if (b_start)
         next_bcnt = next_binit;
      if (w_start)
         next_wcnt = {next_whold_h, next_whold_l};
      next_rdata = 8'h00;
      if (reg_rd)
      begin
         unique case (reg_addr)
            DCT_OFS_BYTE_CTRL:   next_rdata = bctl;
            DCT_OFS_WORD_CTRL:   next_rdata = wctl;
            DCT_OFS_BYTE_INIT:   next_rdata = binit;
            DCT_OFS_WORD_HOLD_L: next_rdata = whold_l;
            DCT_OFS_WORD_HOLD_H: next_rdata = whold_h;
            DCT_OFS_WORD_CAP_L:  next_rdata = wcap_lo;
            DCT_OFS_WORD_CAP_H:  next_rdata = wcap_hi;
            DCT_OFS_BYTE_CAP_L:  next_rdata = bcap_lo;
            DCT_OFS_BYTE_CAP_H:  next_rdata = bcap_hi;
            default:             next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bctl         <= dct_ctrl_s'(DCT_CTRL_RST);
         wctl         <= dct_ctrl_s'(DCT_CTRL_RST);
         binit        <= DCT_DATA_RST;
         whold_l      <= DCT_DATA_RST;
         whold_h      <= DCT_DATA_RST;
         bcap_hi      <= DCT_DATA_RST;
         bcap_lo      <= DCT_DATA_RST;
         wcap_hi      <= DCT_DATA_RST;
         wcap_lo      <= DCT_DATA_RST;
         bcnt         <= DCT_DATA_RST;
         wcnt         <= 16'h0000;
         rise         <= 1'b0;
         fall         <= 1'b0;
         din_d        <= 1'b0;
         bout         <= 1'b0;
         wout         <= 1'b0;
         reg_rdata    <= DCT_DATA_RST;
         byte_tmo_irq <= 1'b0;
         word_tmo_irq <= 1'b0;
         byte_cap_irq <= 1'b0;
         word_cap_irq <= 1'b0;
      end
      else
      begin
         bctl         <= next_bctl;
         wctl         <= next_wctl;
         binit        <= next_binit;
         whold_l      <= next_whold_l;
         whold_h      <= next_whold_h;
         bcap_hi      <= next_bcap_hi;
         bcap_lo      <= next_bcap_lo;
         wcap_hi      <= next_wcap_hi;
         wcap_lo      <= next_wcap_lo;
         bcnt         <= next_bcnt;
         wcnt         <= next_wcnt;
         rise         <= next_rise;
         fall         <= next_fall;
         din_d        <= next_din_d;
         bout         <= next_bout;
         wout         <= next_wout;
         reg_rdata    <= next_rdata;
         byte_tmo_irq <= b_tmo_p;
         word_tmo_irq <= w_tmo_p;
         byte_cap_irq <= b_cap_p;
         word_cap_irq <= w_cap_p;
      end
   end

   always_comb
   begin
      rise_flag            = rise;
      fall_flag            = fall;
      byte_timer_out       = bout;
      word_timer_out       = wout;
      byte_timer_pin_route = bctl.pin_route;
      word_timer_pin_route = wctl.pin_route;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_byte_term;
      b_term && !b_edge;
   endsequence

   a_tmo_set: assert property (s_byte_term |=> bctl.timeout)
      else $error("byte timeout flag not set at terminal count");
   a_tmo_sticky: assert property
      (bctl.timeout && !(wr_b && reg_wdata[DCT_BIT_TIMEOUT]) |=> bctl.timeout)
      else $error("byte timeout flag lost without a clear");
   a_cap_wr_ignored: assert property
      (reg_wr && !b_edge |=> $stable(bcap_hi) && $stable(bcap_lo))
      else $error("byte capture changed by a write");
   a_enable_load: assert property
      (!bctl.run && wr_b && reg_wdata[DCT_BIT_RUN] |=> bcnt == $past(next_binit))
      else $error("byte timer did not load its initial value");
   a_single_stop: assert property
      (s_byte_term ##0 (!demod_mode && bctl.single && !wr_b && !ping_pong)
       |=> !bctl.run)
      else $error("single-pass byte timer kept running");
   a_demod_reload: assert property
      (b_edge |=> bcnt == DCT_BYTE_FULL ##0 byte_cap_irq == $past(bctl.cap_mask))
      else $error("byte capture did not reload all ones");
   a_demod_tmo: assert property
      (s_byte_term ##0 (demod_mode && !wr_b) |=> bcnt == DCT_BYTE_FULL
       && bctl.run && byte_tmo_irq == $past(bctl.tmo_mask))
      else $error("demodulation timeout handled wrongly");
   a_word_ignore: assert property
      (wctl.single && !reg_wr |=> $stable(wcap_hi) && $stable(wcap_lo))
      else $error("word timer captured while edges ignored");
   a_word_split: assert property
      (w_edge |=> {wcap_hi, wcap_lo} == $past(wcnt))
      else $error("word capture bytes mismatched");
   a_cap_mask: assert property
      (w_edge && !wctl.cap_mask |=> !word_cap_irq)
      else $error("masked word capture interrupt raised");
   a_edge_route: assert property
      (b_edge && pos_e |=> bcap_lo == $past(bcnt)
       && bcap_hi == $past(bcap_hi))
      else $error("rising edge not captured to low register");
endmodule
`default_nettype wire

// ===== tb/test_dct_timer.sv
/*
 Self-checking bench for the dual counter/timer block: register table,
 transmit counting, ping-pong chaining and demodulation capture.
 Assumes dct_pkg and dct_timer are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
module test_dct_timer;
   import dct_pkg::*;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic [7:0] rexp;
   } dct_row_s;

   logic       clk        = 1'b0;
   logic       resetn     = 1'b0;
   logic [3:0] reg_addr   = 4'h0;
   logic       reg_wr     = 1'b0;
   logic       reg_rd     = 1'b0;
   logic [7:0] reg_wdata  = 8'h00;
   logic       demod_mode = 1'b0;
   logic       ping_pong  = 1'b0;
   logic [1:0] edge_sel   = 2'b00;
   logic       demod_in   = 1'b0;
   logic       rise_clr   = 1'b0;
   logic       fall_clr   = 1'b0;
   wire  logic [7:0] reg_rdata;
   wire  logic rise_flag, fall_flag, byte_timer_out, word_timer_out;
   wire  logic byte_tmo_irq, word_tmo_irq, byte_cap_irq, word_cap_irq;
   wire  logic byte_timer_pin_route, word_timer_pin_route;
   wire  logic [3:0] irqs;
   int         cnt [4] = '{0, 0, 0, 0};
   int         fail_count  = 0;
   int         check_count = 0;

   assign irqs = {word_cap_irq, byte_cap_irq, word_tmo_irq, byte_tmo_irq};

   always #10 clk = ~clk;

   // Pulse counters for the four interrupt outputs
   always @(posedge clk)
      for (int k = 0; k < 4; k++)
         if (irqs[k] === 1'b1)
            cnt[k] <= cnt[k] + 1;

   dct_timer dct_timer_inst (
      .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .demod_mode(demod_mode), .ping_pong(ping_pong), .edge_sel(edge_sel),
      .demod_in(demod_in), .rise_clr(rise_clr), .fall_clr(fall_clr),
      .rise_flag(rise_flag), .fall_flag(fall_flag),
      .byte_tmo_irq(byte_tmo_irq), .word_tmo_irq(word_tmo_irq),
      .byte_cap_irq(byte_cap_irq), .word_cap_irq(word_cap_irq),
      .byte_timer_out(byte_timer_out), .word_timer_out(word_timer_out),
      .byte_timer_pin_route(byte_timer_pin_route),
      .word_timer_pin_route(word_timer_pin_route)
   );

   task test_done();
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Counts measured against a free-running divider get a small margin
   task check_near(input logic [15:0] got, input logic [15:0] exp,
                   input int tol);
      logic ok;
      ok = (got + tol >= exp) && (got <= exp + tol);
      check(ok ? exp : got, exp);
   endtask

   task step();
      @(posedge clk);
      #1;
   endtask

   task wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      step();
      reg_wr = 1'b0;
      step();
   endtask

   task rd(input logic [3:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd   = 1'b1;
      step();
      d      = reg_rdata;
      reg_rd = 1'b0;
      step();
   endtask

   // Waits for the next pulse on one interrupt; n is cycles waited
   task wait_irq(input int i, input int lim, output int n);
      int c0;
      c0 = cnt[i];
      n  = 0;
      while (cnt[i] == c0 && n < lim)
      begin
         step();
         n++;
      end
      if (cnt[i] == c0)
      begin
         fail_count++;
         $display("ERROR at %0t: no pulse on irq %0d", $time, i);
         test_done();
      end
   endtask

   dct_row_s rows [10] = '{
      '{4'h4, 8'hA5, 8'hA5}, '{4'h6, 8'h5A, 8'h5A}, '{4'h7, 8'hC3, 8'hC3},
      '{4'h8, 8'hFF, 8'h00}, '{4'h9, 8'hFF, 8'h00}, '{4'hA, 8'hFF, 8'h00},
      '{4'hB, 8'hFF, 8'h00}, '{4'hC, 8'h77, 8'h00}, '{4'h0, 8'h19, 8'h19},
      '{4'h2, 8'h07, 8'h07}};
   int       ex_caps [4] = '{1, 1, 2, 0};

   initial
   begin
      logic [7:0] d;
      logic [7:0] e;
      int         n;
      int         c;
      int         w;
      repeat (12) @(posedge clk);
      #1;
      resetn = 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         rd(i[3:0], d);
         check({8'h00, d}, 16'h0000);
      end
      check({12'h0, byte_timer_out, word_timer_out, rise_flag, fall_flag},
            16'h0000);
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, d);
         check({8'h00, d}, {8'h00, rows[i].rexp});
      end
      check({14'h0, byte_timer_pin_route, word_timer_pin_route}, 16'h0003);
      wr(4'h0, 8'h00);
      wr(4'h2, 8'h00);
      // Byte timer single pass
      wr(4'h4, 8'h04);
      wr(4'h0, 8'hC2);
      wait_irq(0, 50, n);
      rd(4'h0, d);
      check({8'h00, d}, 16'h0062);
      check({15'h0, byte_timer_out}, 16'h0001);
      wr(4'h0, 8'h20);
      rd(4'h0, d);
      check({8'h00, d}, 16'h0000);
      // Modulo-N period at every prescale setting
      for (int p = 0; p < 4; p++)
      begin
         wr(4'h4, 8'h03);
         wr(4'h0, {3'b100, p[1:0], 3'b010});
         wait_irq(0, 100, n);
         wait_irq(0, 100, n);
         check(n[15:0], 16'(4 << p));
         rd(4'h0, d);
         check({8'h00, d}, {8'h00, 3'b101, p[1:0], 3'b010});
         wr(4'h0, 8'h20);
      end
      // Word timer single pass
      wr(4'h6, 8'h06);
      wr(4'h7, 8'h00);
      wr(4'h2, 8'hC2);
      rd(4'h2, d);
      check({8'h00, d}, 16'h00C2);
      wait_irq(1, 50, n);
      rd(4'h2, d);
      check({8'h00, d}, 16'h0062);
      check({15'h0, word_timer_out}, 16'h0001);
      // Stop mid-count, restart, full period again
      wr(4'h6, 8'h10);
      wr(4'h2, 8'hA2);
      repeat (6) step();
      wr(4'h2, 8'h00);
      wr(4'h2, 8'h82);
      wait_irq(1, 60, n);
      check_near(n[15:0], 16'd16, 2);
      wr(4'h2, 8'h20);
      // Ping-pong: byte pass must start the word timer
      wr(4'h0, 8'h40);
      wr(4'h2, 8'h42);
      ping_pong = 1'b1;
      wr(4'h4, 8'h03);
      wr(4'h6, 8'h03);
      wr(4'h0, 8'hC0);
      wait_irq(1, 60, n);
      ping_pong = 1'b0;
      wr(4'h0, 8'h20);
      wr(4'h2, 8'h20);
      // Demodulation capture with both edges
      demod_mode = 1'b1;
      edge_sel   = DCT_EDGE_BOTH;
      wr(4'h4, 8'hFF);
      wr(4'h6, 8'hFF);
      wr(4'h7, 8'hFF);
      c = cnt[2];
      w = cnt[3];
      wr(4'h0, 8'h84);
      wr(4'h2, 8'h84);
      repeat (5) step();
      demod_in = 1'b1;
      repeat (20) step();
      demod_in = 1'b0;
      repeat (30) step();
      demod_in = 1'b1;
      repeat (8) step();
      rd(4'hB, d);
      check_near({8'h00, d}, 16'h00FF - 16'd20, 3);
      rd(4'hA, d);
      check_near({8'h00, d}, 16'h00FF - 16'd30, 3);
      rd(4'h9, d);
      rd(4'h8, e);
      check_near({d, e}, 16'hFFFF - 16'd30, 3);
      check(16'(cnt[2] - c), 16'h0003);
      check(16'(cnt[3] - w), 16'h0003);
      check({14'h0, rise_flag, fall_flag}, 16'h0003);
      rise_clr = 1'b1;
      step();
      rise_clr = 1'b0;
      repeat (2) step();
      check({14'h0, rise_flag, fall_flag}, 16'h0001);
      fall_clr = 1'b1;
      step();
      fall_clr = 1'b0;
      repeat (2) step();
      check({14'h0, rise_flag, fall_flag}, 16'h0000);
      // Word edges ignored, byte edges per edge mode
      wr(4'h2, 8'hC4);
      w = cnt[3];
      for (int m = 0; m < 4; m++)
      begin
         edge_sel = m[1:0];
         c        = cnt[2];
         demod_in = 1'b0;
         repeat (10) step();
         demod_in = 1'b1;
         repeat (10) step();
         check(16'(cnt[2] - c), ex_caps[m][15:0]);
      end
      check(16'(cnt[3] - w), 16'h0000);
      // Demodulation timeout keeps counting from all ones
      wr(4'h0, 8'h86);
      wait_irq(0, 300, n);
      wait_irq(0, 300, n);
      check(n[15:0], 16'd256);
      rd(4'h0, d);
      check({8'h00, d & 8'hA0}, 16'h00A0);
      // Reset in mid-run
      resetn = 1'b0;
      step();
      check({8'h00, reg_rdata}, 16'h0000);
      check({8'h00, byte_timer_out, word_timer_out, rise_flag, fall_flag,
             byte_tmo_irq, word_tmo_irq, byte_cap_irq, word_cap_irq},
            16'h0000);
      repeat (11) step();
      resetn = 1'b1;
      rd(4'h0, d);
      check({8'h00, d}, 16'h0000);
      rd(4'h2, d);
      check({8'h00, d}, 16'h0000);
      test_done();
   end
endmodule
`default_nettype wire
